// >>> inc/phase_shed_pkg.sv
// constants and carrier types for the phase shedding and protection control block
package phase_shed_pkg;
  localparam int unsigned    PHASES_MAX      = 8;
  localparam logic [7:0]     PHASE_CFG_ADDR  = 8'h03;
  localparam int unsigned    SHED_CODE_LSB   = 6;
  localparam int unsigned    SHED_CODE_MSB   = 7;
  localparam logic [7:0]     PHASE_CFG_RESET = 8'h00;
  localparam logic [11:0]    PG_HIGH_RESET   = 12'h3ff;
  localparam logic [11:0]    PG_LOW_RESET    = 12'h100;
  localparam logic [11:0]    CROWBAR_RELEASE = 12'h12c; // 300 mV, 1 mV per lsb
  localparam int unsigned    SEQ_STEP_NS     = 1000;
  localparam int unsigned    CLK_PERIOD_NS   = 20;
  localparam int unsigned    SEQ_STEP_CYC    = (SEQ_STEP_NS / CLK_PERIOD_NS) > 0 ?
                                               (SEQ_STEP_NS / CLK_PERIOD_NS) : 1;

  // register write strobe
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_type;

  // outputs towards drivers and supervisor
  typedef struct packed {
    logic [PHASES_MAX-1:0] pwm_run;
    logic                  shed_phase_disable_n;
    logic                  main_phase_disable_n;
    logic                  power_good_out;
    logic                  crowbar;
    logic [2:0]            ilim_div;
  } ctl_out_type;
endpackage : phase_shed_pkg

// >>> core/phase_shed_and_protect_ctl.sv
// phase shedding, output crowbar and enable gating control
`timescale 1ns/1ps

// Functional notes
// - low power input low drives shed disable low
// - config bits 7:6 at 0x03 pick phases
// - eight phase shed sets and limit divisors
// - six phase shed sets and limit divisors
// - other counts run phase one, divisor table
// - sequence phases to limit output deviation
// - overvoltage forces all phase outputs low
// - crowbar holds until output below 300 mV
// - crowbar trip follows power good high limit
// - start only with supply and enable valid
// - disabled holds phases and disables low
// - power good limits are programmable
module phase_shed_and_protect_ctl
  import phase_shed_pkg::*;
#(
  parameter int unsigned NUM_PHASES = 8
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire reg_wr_type            reg_wr_i,
  input  wire logic [11:0]           pg_high_i,
  input  wire logic [11:0]           pg_low_i,
  input  wire logic                  pg_limits_we_i,
  input  wire logic [11:0]           vout_mv_i,
  input  wire logic                  supply_ok_i,
  input  wire logic                  enable_ok_i,
  input  wire logic                  power_state_low_n_i,
  input  wire logic [PHASES_MAX-1:0] pwm_req_i,
  output logic [7:0]                 phase_config_o,
  output ctl_out_type                ctl_o
);

  typedef struct packed {
    logic [7:0]            cfg;
    logic [11:0]           pg_high;
    logic [11:0]           pg_low;
    logic                  crowbar;
    logic                  low_power;
    logic [PHASES_MAX-1:0] run_mask;
    logic [7:0]            step_cnt;
    ctl_out_type           out;
  } state_type;

  state_type st_ff;
  state_type nxt_st;

  logic [PHASES_MAX-1:0] shed_mask;
  logic [2:0]            shed_div;
  logic [PHASES_MAX-1:0] full_mask;
  logic [PHASES_MAX-1:0] phase_gate;
  logic                  enabled;
  logic [1:0]            code;

  assign enabled = supply_ok_i & enable_ok_i;
  assign code    = st_ff.cfg[SHED_CODE_MSB:SHED_CODE_LSB];

  // full phase mask, one bit per configured phase
  genvar g;
  generate
    for (g = 0; g < PHASES_MAX; g++) begin : g_full
      assign full_mask[g] = (g < NUM_PHASES);
      // crowbar overrides every request so the low sides pull the rail down
      assign phase_gate[g] = pwm_req_i[g] & st_ff.run_mask[g] & ~st_ff.crowbar;
    end
  endgenerate

  // phase set and current limit divisor while in low power
  // counts from three to seven that keep only phase one still scale the limit by a divisor picked from the code
  always_comb begin
    shed_mask = 8'h01;
    shed_div  = 3'h1;
    unique case (NUM_PHASES)
      8: begin
        unique case (code)
          2'b00: begin
            shed_mask = 8'h01;
            shed_div  = 3'h4;
          end
          2'b01: begin
            shed_mask = 8'h11;
            shed_div  = 3'h4;
          end
          2'b10, 2'b11: begin
            shed_mask = 8'h55;
            shed_div  = 3'h2;
          end
        endcase
      end
      7: begin
        // only phase one stays, the divisor still follows the code
        unique case (code)
          2'b00, 2'b01: begin
            shed_div = 3'h4;
          end
          2'b10, 2'b11: begin
            shed_div = 3'h2;
          end
        endcase
      end
      6: begin
        // code 11 follows the phase list, not the printed count
        unique case (code)
          2'b00: begin
            shed_mask = 8'h01;
            shed_div  = 3'h4;
          end
          2'b01: begin
            shed_mask = 8'h09;
            shed_div  = 3'h3;
          end
          2'b10, 2'b11: begin
            shed_mask = 8'h15;
            shed_div  = 3'h2;
          end
        endcase
      end
      5, 4: begin
        unique case (code)
          2'b00: begin
            shed_div = 3'h4;
          end
          2'b01, 2'b10, 2'b11: begin
            shed_div = 3'h2;
          end
        endcase
      end
      3: begin
        unique case (code)
          2'b00: begin
            shed_div = 3'h3;
          end
          2'b01, 2'b10, 2'b11: begin
            shed_div = 3'h2;
          end
        endcase
      end
      2: begin
        shed_div = 3'h2;
      end
      1: begin
        shed_div = 3'h1;
      end
      default: begin
        // outside one to eight phases: keep phase one at full limit
        shed_div = 3'h1;
      end
    endcase
  end

  // next state
  always_comb begin
    nxt_st = st_ff;
    if (reg_wr_i.we && reg_wr_i.addr == PHASE_CFG_ADDR) begin
      nxt_st.cfg = reg_wr_i.data;
    end
    if (pg_limits_we_i) begin
      nxt_st.pg_high = pg_high_i;
      nxt_st.pg_low  = pg_low_i;
    end
    // crowbar: trip above power good high, release below 300 mV
    if (vout_mv_i > st_ff.pg_high) begin
      nxt_st.crowbar = 1'b1;
    end else if (vout_mv_i < CROWBAR_RELEASE) begin
      nxt_st.crowbar = 1'b0;
    end
    // low power request is a plain level, acted on one cycle later
    nxt_st.low_power = ~power_state_low_n_i;
    // sequencing: entering sheds after a settling step; exit restores at once
    if (!st_ff.low_power) begin
      nxt_st.run_mask = full_mask;
      nxt_st.step_cnt = 8'h00;
    end else if (st_ff.step_cnt < 8'(SEQ_STEP_CYC)) begin
      nxt_st.step_cnt = st_ff.step_cnt + 8'h01;
    end else begin
      nxt_st.run_mask = shed_mask & full_mask;
    end
    // outputs pass one more flop so every pin leaves a register
    // shed drivers go off at once; their pwm is masked after the settling step
    nxt_st.out.shed_phase_disable_n = enabled & ~st_ff.low_power;
    nxt_st.out.main_phase_disable_n = enabled;
    nxt_st.out.ilim_div = st_ff.low_power ? shed_div : 3'h1;
    nxt_st.out.crowbar  = st_ff.crowbar;
    // per phase gate, crowbar already folded in
    nxt_st.out.pwm_run  = phase_gate;
    // power good window is inclusive at both limits
    nxt_st.out.power_good_out = enabled & (vout_mv_i <= st_ff.pg_high) &
                                (vout_mv_i >= st_ff.pg_low);
    if (!enabled) begin
      // drivers grounded so output caps cannot discharge through them
      nxt_st.out.pwm_run              = 8'h00;
      nxt_st.out.power_good_out       = 1'b0;
      nxt_st.out.shed_phase_disable_n = 1'b0;
      nxt_st.out.main_phase_disable_n = 1'b0;
      nxt_st.run_mask                 = full_mask;
      nxt_st.step_cnt                 = 8'h00;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_ff         <= '0;
      st_ff.cfg     <= PHASE_CFG_RESET;
      st_ff.pg_high <= PG_HIGH_RESET;
      st_ff.pg_low  <= PG_LOW_RESET;
      st_ff.out.ilim_div <= 3'h1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign phase_config_o = st_ff.cfg;
  assign ctl_o          = st_ff.out;
endmodule : phase_shed_and_protect_ctl

// >>> bench/phase_shed_props.sv
// port assertions for the shedding and crowbar control
`timescale 1ns/1ps
module phase_shed_props import phase_shed_pkg::*; #(parameter int unsigned NUM_PHASES = 8) (
  input wire logic        clk_i, rst_n_i, pg_limits_we_i, supply_ok_i, enable_ok_i,
  input wire logic        power_state_low_n_i,
  input wire reg_wr_type  reg_wr_i,
  input wire logic [11:0] pg_high_i, pg_low_i, vout_mv_i,
  input wire logic [7:0]  pwm_req_i, phase_config_o,
  input wire ctl_out_type ctl_o
);
  logic [11:0] hi_ff;
  wire         on = supply_ok_i && enable_ok_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // mirror of the loaded high limit, the trip level follows it
  always_ff @(posedge clk_i) if (!rst_n_i) hi_ff <= PG_HIGH_RESET;
    else if (pg_limits_we_i) hi_ff <= pg_high_i;
  AST_CFG_WR: assert property (reg_wr_i.we && reg_wr_i.addr == PHASE_CFG_ADDR |=>
    phase_config_o == $past(reg_wr_i.data)) else $error("config write lost");
  AST_CFG_KEEP: assert property (reg_wr_i.we && reg_wr_i.addr != PHASE_CFG_ADDR |=>
    $stable(phase_config_o)) else $error("config changed by foreign write");
  AST_OFF: assert property (!on [*3] |-> ctl_o.pwm_run == '0 && !ctl_o.power_good_out &&
    !ctl_o.shed_phase_disable_n && !ctl_o.main_phase_disable_n) else $error("not held off");
  AST_SHED: assert property ((on && !power_state_low_n_i) [*3] |->
    !ctl_o.shed_phase_disable_n) else $error("shed disable not low");
  AST_EXIT: assert property ((on && power_state_low_n_i) [*3] |->
    ctl_o.shed_phase_disable_n) else $error("shed disable not released");
  AST_BAR_LOW: assert property (ctl_o.crowbar [*2] |-> ctl_o.pwm_run == '0)
    else $error("phase driven during crowbar");
  AST_TRIP: assert property ((on && vout_mv_i > hi_ff) [*3] |-> ctl_o.crowbar)
    else $error("crowbar did not trip");
  AST_HOLD: assert property (ctl_o.crowbar && vout_mv_i >= CROWBAR_RELEASE |=>
    ctl_o.crowbar) else $error("crowbar released early");
  AST_GATE: assert property ((ctl_o.pwm_run & ~$past(pwm_req_i)) == '0)
    else $error("phase runs without request");
  cover property ($rose(ctl_o.crowbar));
  cover property ($fell(ctl_o.shed_phase_disable_n));
  cover property (reg_wr_i.we && reg_wr_i.addr != PHASE_CFG_ADDR);
endmodule : phase_shed_props
bind phase_shed_and_protect_ctl phase_shed_props #(.NUM_PHASES(NUM_PHASES)) props_inst (.*);

// >>> bench/gate_driver_model.sv
// behavioural external gate drivers, phase 1 on the main disable
`timescale 1ns/1ps
module gate_driver_model import phase_shed_pkg::*; (
  input  wire logic [7:0] pwm_i,
  input  wire logic       main_n_i,
  input  wire logic       shed_n_i,
  output logic [7:0]      high_side_gate_o,
  output logic [7:0]      low_side_gate_o
);
  wire [7:0] on = {{7{shed_n_i}}, main_n_i};
  // disabled driver grounds both gates, keeps output caps charged
  assign high_side_gate_o = pwm_i & on;
  assign low_side_gate_o  = ~pwm_i & on;
endmodule : gate_driver_model

// >>> bench/tb_phase_shed_and_protect_ctl.sv
// self-checking bench for the shedding and crowbar control
`timescale 1ns/1ps
module tb_phase_shed_and_protect_ctl import phase_shed_pkg::*;;
  logic        clk, rst_n = 0, pg_we = 0, sup = 1, en = 1, psl_n = 1, look = 0;
  reg_wr_type  reg_wr = '0;
  logic [11:0] pg_hi = 12'h3ff, pg_lo = 12'h100, vout = 12'h150;
  logic [7:0]  req = 8'hff, cfg, d, hsg, lsg;
  logic [30:0] exp_q[$];
  logic [31:0] rnd = 32'hf18fab73;
  ctl_out_type ctl;
  int          n_mismatch = 0, num_checks = 0;
  phase_shed_and_protect_ctl #(.NUM_PHASES(8)) phase_shed_and_protect_ctl_inst (.clk_i(clk),
    .rst_n_i(rst_n), .reg_wr_i(reg_wr), .pg_high_i(pg_hi), .pg_low_i(pg_lo),
    .pg_limits_we_i(pg_we), .vout_mv_i(vout), .supply_ok_i(sup), .enable_ok_i(en),
    .power_state_low_n_i(psl_n), .pwm_req_i(req), .phase_config_o(cfg), .ctl_o(ctl));
  gate_driver_model gate_driver_model_inst (.pwm_i(ctl.pwm_run), .main_n_i(ctl.main_phase_disable_n),
    .shed_n_i(ctl.shed_phase_disable_n), .high_side_gate_o(hsg), .low_side_gate_o(lsg));
  // expected {driver enables, config, outputs}; ds is {shed, main}
  function automatic logic [30:0] ex(logic [7:0] c, m, logic [2:0] dv, logic [1:0] ds, logic pg, cb);
    return {{7{ds[1]}}, ds[0], c, m, ds, pg, cb, dv};
  endfunction : ex
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  task automatic check(logic [30:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] outputs exp %h seen %h", exp, seen);
    end
  endtask : check
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // note one expectation, the monitor samples at the next edge
  task automatic note(logic [30:0] e);
    exp_q.push_back(e);
    look <= 1'b1;
    cyc(1);
    look <= 1'b0;
  endtask : note
  task automatic wr(logic [7:0] a, dt);
    reg_wr <= '{1'b1, a, dt};
    cyc(1);
    reg_wr.we <= 1'b0;
    cyc(1);
  endtask : wr
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (look) check({hsg | lsg, cfg, ctl}, exp_q.pop_front());
  initial begin
    cyc(2000); // whole run is under 600 cycles
    n_mismatch++;
    print_verdict();
  end
  initial begin : main
    int c;
    cyc(6);
    rst_n <= 1;
    cyc(4);
    note(ex(8'h00, 8'hff, 3'd1, 2'b11, 1, 0));
    rnd = xs(rnd);
    d = rnd[7:0];
    wr(PHASE_CFG_ADDR, d);
    wr(8'h04, ~d);
    note(ex(d, 8'hff, 3'd1, 2'b11, 1, 0));
    $display("config test done");
    // every shed code; wait covers the sequencing step
    for (c = 0; c < 4; c++) begin
      wr(PHASE_CFG_ADDR, {c[1:0], 6'h00});
      psl_n <= 0;
      cyc(SEQ_STEP_CYC + 10);
      note(ex({c[1:0], 6'h00}, c == 0 ? 8'h01 : c == 1 ? 8'h11 : 8'h55,
        c < 2 ? 3'd4 : 3'd2, 2'b01, 1, 0));
      psl_n <= 1;
      cyc(4);
      note(ex({c[1:0], 6'h00}, 8'hff, 3'd1, 2'b11, 1, 0));
    end
    $display("shed test done");
    pg_hi <= 12'h200;
    pg_we <= 1;
    cyc(1);
    pg_we <= 0;
    vout <= 12'h201;
    cyc(4);
    note(ex(8'hc0, 8'h00, 3'd1, 2'b11, 0, 1));
    vout <= 12'h12d;
    cyc(4);
    note(ex(8'hc0, 8'h00, 3'd1, 2'b11, 1, 1));
    vout <= 12'h12b;
    cyc(4);
    note(ex(8'hc0, 8'hff, 3'd1, 2'b11, 1, 0));
    pg_lo <= 12'h130;
    pg_we <= 1;
    cyc(1);
    pg_we <= 0;
    cyc(4);
    note(ex(8'hc0, 8'hff, 3'd1, 2'b11, 0, 0));
    sup <= 0;
    cyc(4);
    note(ex(8'hc0, 8'h00, 3'd1, 2'b00, 0, 0));
    sup <= 1;
    en <= 0;
    cyc(4);
    note(ex(8'hc0, 8'h00, 3'd1, 2'b00, 0, 0));
    $display("protect test done");
    print_verdict();
  end
endmodule : tb_phase_shed_and_protect_ctl
